// >>> core/rx_decode_built_in_selftest_elastic.sv
// Purpose: one receive channel back end: 10b/8b decode, parity, self-test checker, elasticity buffer
// Assumes: char_strobe marks a framed character from the recovered clock; ticks are hclk-synchronous
// Notes:   registers over AHB-Lite, zero wait states
// What this block does
// - decoder on: decode 10-bit characters to bytes
// - status 000b data, 001b special
// - decoder off: raw output, no buffer, no bonding
// - bypass drives per-channel recovered clock output
// - mid select: native special-code column
// - high select: alternate special-code column
// - odd parity over the low eight bits of every output character
// - latch open: low enable starts self-test
// - latch closed: hold captured enables
// - device reset forces captured enables high
// - 511-character LFSR checks received characters
// - checker starts at loop start D0.0
// - loop violations are not errors
// - loop completion status one character
// - self-test status same in every decoder mode; decoder off reports loop completion as set A even when set B is selected
// - invalid lead of 16 restarts hunt
// - buffer holds ten 12-bit entries
// - written by own clock, read by selected
// - buffers realign bonded channels
// - receive mode sets bonding and status set
// - reference clocking inserts K28.5, deletes framing; not under high decoder select, which stores K28.5 as 97h
// - mid clock select bypasses the buffer
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module rx_decode_built_in_selftest_elastic
  import rx_codec_pkg::*;
(
  // bus clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // character input and clock ticks
  input  wire logic [9:0]  char_in,
  input  wire logic        char_strobe,
  input  wire logic        ref_tick,
  input  wire logic        alt_tick,
  input  wire logic        bond_align,
  input  wire logic        device_reset_low,
  // receive output
  output logic [9:0]       rx_data,
  output logic [2:0]       receive_status_bits,
  output logic             rx_parity,
  output logic             rx_valid,
  output logic             recovered_clock_output,
  output logic             shared_clock_output
);
  import rx_codec_pkg::*;

  function automatic logic [9:0] decode_char(input logic [9:0] ch);
    logic [5:0] six;
    logic [3:0] four;
    logic       hit6;
    logic       hit4;
    logic       k28;
    logic       a7;
    logic       spec;
    logic [4:0] x;
    logic [2:0] y;
    six  = ch[9:4];
    four = ch[3:0];
    hit6 = 1'b0;
    hit4 = 1'b0;
    x    = 5'h00;
    y    = 3'h0;
    // balanced groups other than D.7 / x.3 have one form only; complementing them would alias
    for (int i = 0; i < 32; i++)
      if (six == ENC6[i] || (($countones(ENC6[i]) != 3 || i == 7) && six == ~ENC6[i]))
      begin
        hit6 = 1'b1;
        x    = 5'(i);
      end
    for (int j = 0; j < 8; j++)
      if (four == ENC4[j] || (($countones(ENC4[j]) != 2 || j == 3) && four == ~ENC4[j]))
      begin
        hit4 = 1'b1;
        y    = 3'(j);
      end
    k28 = (six == K28_6B) || (six == ~K28_6B);
    a7  = (four == A7_4B) || (four == ~A7_4B);
    if (a7)
      y = 3'h7;
    if (k28)
      x = 5'd28;
    spec = k28 || (a7 && (x == 5'd23 || x == 5'd27 || x == 5'd29 || x == 5'd30));
    return {(hit6 || k28) && (hit4 || a7), spec, y, x};
  endfunction : decode_char

  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    return (p == EB_LAST) ? 4'h0 : 4'(p + 4'h1);
  endfunction : ptr_inc

  function automatic level_type level_of(input level_type v);
    return (v == 2'h3) ? LVL_MID : v;
  endfunction : level_of

  // register file
  logic [11:0]    ctrl_r;
  logic [15:0]    err_count_r;
  logic [15:0]    loop_count_r;
  logic           ovf_r;
  logic           unf_r;
  logic           wr_pend_r;
  logic [7:0]     wr_addr_r;
  // self-test
  logic           captured_en_r;
  logic           active_d_r;
  built_in_selftest_state_type built_in_selftest_state_r;
  logic [8:0]     lfsr_r;
  logic [4:0]     diff_r;
  // elasticity buffer
  logic [EB_WIDTH-1:0] eb_mem_r [EB_DEPTH];
  logic [3:0]     wr_ptr_r;
  logic [3:0]     rd_ptr_r;
  logic [3:0]     eb_count_r;

  level_type dec_sel;
  level_type clk_sel;
  level_type mode_hi;
  level_type mode_lo;
  logic       dec_on;
  logic       bonded;
  logic       set_b;
  logic       direct;
  logic       cfg_err;
  logic [9:0] dec;
  logic [7:0] byte_out;
  logic       built_in_selftest_on;
  logic       exp_special;
  logic       match;
  logic       loop_done;
  logic       mism;
  logic [2:0] status_nxt;
  logic       read_tick;
  logic [EB_WIDTH-1:0] head;
  logic [EB_WIDTH-1:0] head2;
  logic       head_frame;
  logic       do_write;
  logic       do_insert;
  logic       do_delete;
  logic       pop;
  logic       realign;
  logic [8:0] lfsr_nxt;

  assign dec_sel = level_of(ctrl_r[CTL_DEC_POS +: 2]);
  assign clk_sel = level_of(ctrl_r[CTL_CLK_POS +: 2]);
  assign mode_hi = level_of(ctrl_r[CTL_MODE_POS+2 +: 2]);
  assign mode_lo = level_of(ctrl_r[CTL_MODE_POS +: 2]);
  assign dec_on  = (dec_sel != LVL_LOW);
  assign bonded  = dec_on && (mode_hi != LVL_LOW);
  assign set_b   = dec_on && (mode_lo == LVL_HIGH);
  // decoder bypass forces the direct path whatever the clock select says
  assign direct  = !dec_on || (clk_sel == LVL_MID);
  assign cfg_err = !dec_on && (clk_sel != LVL_MID);
  assign dec     = decode_char(char_in);
  // reserved mode codes report like status set A
  assign byte_out = (dec[8] && dec_sel == LVL_HIGH) ? {dec[2:0], dec[7:3]} : dec[7:0];

  // self-test compare
  assign built_in_selftest_on     = (built_in_selftest_state_r != BUILT_IN_SELFTEST_OFF);
  assign exp_special = lfsr_r[8];
  assign lfsr_nxt    = {lfsr_r[7:0], ~(lfsr_r[8] ^ lfsr_r[4])};
  // special slots of the loop carry violations on purpose, so any non-data there is a match
  assign match     = exp_special ? (dec[8] || !dec[9])
                                 : (dec[9] && !dec[8] && dec[7:0] == lfsr_r[7:0]);
  assign loop_done = (built_in_selftest_state_r == BUILT_IN_SELFTEST_RUN) && match && (lfsr_nxt == LFSR_START);
  assign mism      = (built_in_selftest_state_r == BUILT_IN_SELFTEST_RUN) && !match;

  always_comb
  begin
    if (loop_done)
      status_nxt = set_b ? ST_LOOP_B : ST_LOOP_A;
    else if (mism)
      status_nxt = ST_BUILT_IN_SELFTEST_ERR;
    else if (!dec[9])
      status_nxt = ST_INVALID;
    else if (dec[8] && set_b && dec[7:0] == K28_5_BYTE)
      status_nxt = ST_FRAME_B;
    else if (dec[8])
      status_nxt = ST_SPECIAL;
    else
      status_nxt = ST_DATA;
  end

  // self-test enable latch: transparent while the latch enable is high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      captured_en_r <= 1'b1;
    else if (!device_reset_low)
      captured_en_r <= 1'b1;
    else if (ctrl_r[CTL_BLE_POS])
      captured_en_r <= ctrl_r[CTL_BEN_POS];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      active_d_r <= 1'b0;
    else
      active_d_r <= !captured_en_r;
  end

  // checker state machine
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      built_in_selftest_state_r <= BUILT_IN_SELFTEST_OFF;
      lfsr_r       <= LFSR_START;
      diff_r       <= 5'h00;
    end
    else if (captured_en_r)
    begin
      built_in_selftest_state_r <= BUILT_IN_SELFTEST_OFF;
      lfsr_r       <= LFSR_START;
      diff_r       <= 5'h00;
    end
    else
    begin
      case (built_in_selftest_state_r)
        BUILT_IN_SELFTEST_OFF:
        begin
          if (active_d_r)
          begin
            built_in_selftest_state_r <= BUILT_IN_SELFTEST_HUNT;
            lfsr_r       <= LFSR_START;
            diff_r       <= 5'h00;
          end
        end
        BUILT_IN_SELFTEST_HUNT:
        begin
          if (char_strobe && dec[9] && !dec[8] && dec[7:0] == D0_0_BYTE)
          begin
            built_in_selftest_state_r <= BUILT_IN_SELFTEST_RUN;
            lfsr_r       <= lfsr_nxt;
          end
        end
        BUILT_IN_SELFTEST_RUN:
        begin
          if (char_strobe && mism && diff_r == BUILT_IN_SELFTEST_ABORT - 5'h01)
          begin
            built_in_selftest_state_r <= BUILT_IN_SELFTEST_HUNT;
            lfsr_r       <= LFSR_START;
            diff_r       <= 5'h00;
          end
          else if (char_strobe)
          begin
            lfsr_r <= lfsr_nxt;
            if (mism)
              diff_r <= 5'(diff_r + 5'h01);
            else if (diff_r != 5'h00)
              diff_r <= 5'(diff_r - 5'h01);
          end
        end
        default:
          built_in_selftest_state_r <= BUILT_IN_SELFTEST_OFF;
      endcase
    end
  end

  // elasticity buffer control
  assign read_tick  = (clk_sel == LVL_LOW) ? ref_tick : alt_tick;
  assign head       = eb_mem_r[rd_ptr_r];
  assign head2      = eb_mem_r[ptr_inc(rd_ptr_r)];
  assign head_frame = (head[11:9] == ST_SPECIAL || head[11:9] == ST_FRAME_B) && head[7:0] == K28_5_BYTE;
  assign do_write   = char_strobe && !direct && eb_count_r != EB_FULL;
  assign realign    = !direct && ((bonded && bond_align) || !device_reset_low);
  // slips only on framing characters and only under reference clocking
  assign do_insert  = read_tick && clk_sel == LVL_LOW && head_frame && eb_count_r <= EB_LOW_MARK;
  assign do_delete  = read_tick && clk_sel == LVL_LOW && head_frame && eb_count_r >= EB_HIGH_MARK;
  assign pop        = read_tick && !direct && eb_count_r != 4'h0 && !do_insert;

  always_ff @(posedge hclk)
  begin
    if (do_write)
      eb_mem_r[wr_ptr_r] <= {status_nxt, ~^byte_out, byte_out};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr_r   <= 4'h0;
      rd_ptr_r   <= 4'h0;
      eb_count_r <= 4'h0;
    end
    else if (direct)
    begin
      wr_ptr_r   <= 4'h0;
      rd_ptr_r   <= 4'h0;
      eb_count_r <= 4'h0;
    end
    else if (realign)
    begin
      // re-centre so bonded channels leave the buffers in step
      rd_ptr_r   <= (wr_ptr_r >= EB_CENTER) ? 4'(wr_ptr_r - EB_CENTER)
                                           : 4'(wr_ptr_r + 4'(EB_DEPTH) - EB_CENTER);
      eb_count_r <= EB_CENTER;
    end
    else
    begin
      if (do_write)
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (pop && do_delete)
        rd_ptr_r <= ptr_inc(ptr_inc(rd_ptr_r));
      else if (pop)
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      eb_count_r <= 4'(eb_count_r + {3'h0, do_write} - {3'h0, pop} - {3'h0, pop && do_delete});
    end
  end

  // output register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_data                <= 10'h000;
      receive_status_bits    <= ST_DATA;
      rx_parity              <= 1'b1;
      rx_valid               <= 1'b0;
      recovered_clock_output <= 1'b0;
      shared_clock_output    <= 1'b0;
    end
    else
    begin
      recovered_clock_output <= direct && char_strobe;
      shared_clock_output    <= !direct && read_tick;
      rx_valid               <= direct ? char_strobe : (read_tick && (eb_count_r != 4'h0));
      if (direct && char_strobe)
      begin
        rx_data             <= dec_on ? {2'h0, byte_out} : char_in;
        receive_status_bits <= status_nxt;
        rx_parity           <= dec_on ? ~^byte_out : ~^char_in[7:0];
      end
      else if (!direct && read_tick && eb_count_r != 4'h0)
      begin
        rx_data             <= {2'h0, do_delete ? head2[7:0] : head[7:0]};
        receive_status_bits <= do_delete ? head2[11:9] : head[11:9];
        rx_parity           <= do_delete ? head2[8] : head[8];
      end
    end
  end

  // bus slave: address phase captured, write data applied in the following cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= hsel && hready && htrans[1] && hwrite;
      wr_addr_r <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite)
      begin
        if (haddr[7:0] == CTRL_OFFSET)
          hrdata <= {20'h00000, ctrl_r};
        else if (haddr[7:0] == STATUS_OFFSET)
          hrdata <= {18'h00000, cfg_err, diff_r, eb_count_r, unf_r, ovf_r, built_in_selftest_state_r};
        else if (haddr[7:0] == COUNT_OFFSET)
          hrdata <= {loop_count_r, err_count_r};
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_r <= CTRL_RESET;
    else if (wr_pend_r && wr_addr_r == CTRL_OFFSET)
      ctrl_r <= hwdata[11:0];
  end

  // sticky buffer faults: a new event beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end
    else
    begin
      if (char_strobe && !direct && eb_count_r == EB_FULL)
        ovf_r <= 1'b1;
      else if (wr_pend_r && wr_addr_r == STATUS_OFFSET && hwdata[STS_OVF_POS])
        ovf_r <= 1'b0;
      if (read_tick && !direct && eb_count_r == 4'h0)
        unf_r <= 1'b1;
      else if (wr_pend_r && wr_addr_r == STATUS_OFFSET && hwdata[STS_UNF_POS])
        unf_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      err_count_r  <= 16'h0000;
      loop_count_r <= 16'h0000;
    end
    else if (active_d_r && captured_en_r)
    begin
      err_count_r  <= 16'h0000;
      loop_count_r <= 16'h0000;
    end
    else if (char_strobe)
    begin
      if (mism && err_count_r != 16'hFFFF)
        err_count_r <= 16'(err_count_r + 16'h0001);
      if (loop_done)
        loop_count_r <= 16'(loop_count_r + 16'h0001);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_raw_bypass: assert property (!dec_on && char_strobe |=> rx_data == $past(char_in) && rx_valid)
    else $error("raw character not passed in decoder bypass");
  a_data_status: assert property (direct && dec_on && char_strobe && !built_in_selftest_on && dec[9] && !dec[8]
                                  |=> receive_status_bits == ST_DATA)
    else $error("valid data character not flagged 000");
  a_odd_parity: assert property (rx_valid && dec_on |-> ^{rx_parity, rx_data[7:0]})
    else $error("output parity not odd");
  a_latch_hold: assert property (!ctrl_r[CTL_BLE_POS] && $past(!ctrl_r[CTL_BLE_POS]) && $past(device_reset_low)
                                 |-> $stable(captured_en_r))
    else $error("captured enable changed while latch closed");
  a_reset_disable: assert property (!device_reset_low |=> captured_en_r ##1 !built_in_selftest_on)
    else $error("device reset did not disable self-test");
  a_hunt_start: assert property (built_in_selftest_state_r == BUILT_IN_SELFTEST_HUNT |-> lfsr_r == LFSR_START)
    else $error("hunt state without loop start code");
  a_abort_lead: assert property (char_strobe && mism && diff_r == 5'h0F && !captured_en_r
                                 |=> built_in_selftest_state_r == BUILT_IN_SELFTEST_HUNT && diff_r == 5'h00)
    else $error("checker did not restart after invalid lead of 16");
  a_loop_status: assert property (direct && char_strobe && loop_done && !captured_en_r
                                  |=> receive_status_bits == (set_b ? ST_LOOP_B : ST_LOOP_A))
    else $error("loop completion not reported");
  a_buffer_bound: assert property (eb_count_r <= EB_FULL)
    else $error("elasticity buffer count out of range");
  a_bypass_clock: assert property (direct && char_strobe |=> recovered_clock_output && !shared_clock_output)
    else $error("per-channel clock output missing in bypass");
  a_buffer_skip: assert property (direct |=> eb_count_r == 4'h0)
    else $error("buffer in use while bypassed");

  c_loop_done: cover property (char_strobe && loop_done);
  c_abort: cover property (char_strobe && mism && diff_r == 5'h0F);
  c_insert: cover property (do_insert && !direct);
  c_delete: cover property (do_delete && pop);
endmodule : rx_decode_built_in_selftest_elastic
`default_nettype wire

// >>> include/rx_codec_pkg.sv
// Purpose: constants and types shared by the receive decode / self-test / elasticity block
// Assumes: 10-bit characters arrive as {a,b,c,d,e,i,f,g,h,j}, bit 9 = a
// Notes:   three-level selects are two-bit codes; 2'h3 reads as mid (open)
package rx_codec_pkg;
  typedef logic [1:0] level_type;
  typedef enum logic [1:0] {BUILT_IN_SELFTEST_OFF, BUILT_IN_SELFTEST_HUNT, BUILT_IN_SELFTEST_RUN} built_in_selftest_state_type;

  localparam level_type   LVL_LOW   = 2'h0;
  localparam level_type   LVL_MID   = 2'h1;
  localparam level_type   LVL_HIGH  = 2'h2;
  // register map, byte addresses
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET = 8'h04;
  localparam logic [7:0]  COUNT_OFFSET  = 8'h08;
  // control fields
  localparam int          CTL_DEC_POS   = 0;
  localparam int          CTL_CLK_POS   = 2;
  localparam int          CTL_MODE_POS  = 4;
  localparam int          CTL_FRM_POS   = 8;
  localparam int          CTL_BEN_POS   = 10;
  localparam int          CTL_BLE_POS   = 11;
  localparam logic [11:0] CTRL_RESET    = 12'hD15;
  // status fields
  localparam int          STS_OVF_POS   = 2;
  localparam int          STS_UNF_POS   = 3;
  // receive status codes
  localparam logic [2:0]  ST_DATA       = 3'h0;
  localparam logic [2:0]  ST_SPECIAL    = 3'h1;
  localparam logic [2:0]  ST_LOOP_A     = 3'h2;
  localparam logic [2:0]  ST_FRAME_B    = 3'h3;
  localparam logic [2:0]  ST_LOOP_B     = 3'h4;
  localparam logic [2:0]  ST_BUILT_IN_SELFTEST_ERR   = 3'h6;
  localparam logic [2:0]  ST_INVALID    = 3'h7;
  // elasticity buffer
  localparam int          EB_DEPTH      = 10;
  localparam int          EB_WIDTH      = 12;
  localparam logic [3:0]  EB_LAST       = 4'h9;
  localparam logic [3:0]  EB_FULL       = 4'hA;
  localparam logic [3:0]  EB_CENTER     = 4'h5;
  localparam logic [3:0]  EB_LOW_MARK   = 4'h2;
  localparam logic [3:0]  EB_HIGH_MARK  = 4'h8;
  // self-test
  localparam logic [8:0]  LFSR_START    = 9'h000;
  localparam logic [4:0]  BUILT_IN_SELFTEST_ABORT    = 5'h10;
  // code points
  localparam logic [7:0]  K28_5_BYTE    = 8'hBC;
  localparam logic [7:0]  D0_0_BYTE     = 8'h00;
  localparam logic [5:0]  K28_6B        = 6'h0F;
  localparam logic [3:0]  A7_4B         = 4'h7;
  // negative-disparity 5b/6b and 3b/4b code groups
  localparam logic [5:0]  ENC6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
                                        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
                                        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
                                        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0]  ENC4 [8]  = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
endpackage : rx_codec_pkg

// >>> verif/char_source.sv
// Purpose: far-side character source standing in for the remote transmitter and framer
// Assumes: the receiver is already framed; a request on send becomes one strobe a cycle later
// Notes:   between characters the data lines invert every cycle, alternating between the inverse of the last value and the value itself
`timescale 1ns/1ns
`default_nettype none
module char_source
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // request from the bench
  input  wire logic       send,
  input  wire logic [9:0] char_val,
  // framed character towards the block
  output logic [9:0]      char_in,
  output logic            char_strobe
);
  // self-test runs with the direct clock select, so no word sync is prefixed here
  // characters are sent already framed, as a multi-byte framer needs before self
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      char_strobe <= 1'b0;
      char_in     <= 10'h000;
    end
    else
    begin
      char_strobe <= send;
      char_in     <= send ? char_val : ~char_in;
    end
  end
endmodule : char_source
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the receive decode, self-test and clock-select logic
// Assumes: single AHB-Lite slave, hready taken from hreadyout, zero wait states not relied on
// Notes:   buffered path read with the alternate tick; reference ticks and bonded realign stay idle
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import rx_codec_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic [9:0]  char_in;
  logic        char_strobe;
  logic        snd;
  logic [9:0]  cval;
  logic        device_reset_low;
  logic [9:0]  rx_data;
  logic [2:0]  rx_st;
  logic        rx_parity;
  logic        rx_valid;
  logic        rec_clk;
  logic        sh_clk;
  logic        atk;
  logic [31:0] rdv;
  int          n_mismatch;
  int          n_tests;
  int          cycles;
  rx_decode_built_in_selftest_elastic dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
    .hresp(hresp), .char_in(char_in), .char_strobe(char_strobe), .ref_tick(1'b0), .alt_tick(atk),
    .bond_align(1'b0), .device_reset_low(device_reset_low), .rx_data(rx_data), .receive_status_bits(rx_st),
    .rx_parity(rx_parity), .rx_valid(rx_valid), .recovered_clock_output(rec_clk), .shared_clock_output(sh_clk));
  char_source src (.hclk(hclk), .hresetn(hresetn), .send(snd), .char_val(cval), .char_in(char_in),
    .char_strobe(char_strobe));
  task test_done;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= a;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask : bus
  // one character through the source, outputs checked in the cycle the valid pulse stands
  task rx(input logic [9:0] c, input logic [9:0] d, input logic [2:0] st);
    @(posedge hclk);
    snd  <= 1'b1;
    cval <= c;
    @(posedge hclk);
    snd  <= 1'b0;
    @(posedge hclk);
    #1;
    chk("rx_valid", 32'h1, {31'h0, rx_valid});
    chk("rx_data", {22'h0, d}, {22'h0, rx_data});
    chk("status", {29'h0, st}, {29'h0, rx_st});
    chk("parity", {31'h0, ~^d[7:0]}, {31'h0, rx_parity});
  endtask : rx
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  initial
  begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, snd, cval, atk} = '0;
    device_reset_low = 1'b1;
    n_mismatch = 0;
    n_tests = 0;
    cycles = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk("parity_rst", 32'h1, {31'h0, rx_parity});
    bus(1'b0, 32'h0, 32'h0);
    chk("ctrl_rst", 32'hD15, rdv);
    chk("hresp", 32'h0, {31'h0, hresp});
    rx(10'h27B, 10'h000, ST_DATA);
    rx(10'h1DB, 10'h001, ST_DATA);
    rx(10'h0FA, 10'h0BC, ST_SPECIAL);
    bus(1'b1, 32'h0, 32'hD16);
    rx(10'h0FA, 10'h097, ST_SPECIAL);
    rx(10'h1DB, 10'h001, ST_DATA);
    bus(1'b1, 32'h0, 32'hD14);
    rx(10'h1DB, 10'h1DB, 3'h0);
    chk("rec_clk", 32'h1, {31'h0, rec_clk});
    chk("shared_clk", 32'h0, {31'h0, sh_clk});
    bus(1'b0, 32'h4, 32'h0);
    chk("cfg_err", 32'h0, {31'h0, rdv[13]});
    bus(1'b1, 32'h0, 32'hD10);
    bus(1'b0, 32'h4, 32'h0);
    chk("cfg_err", 32'h1, {31'h0, rdv[13]});
    bus(1'b0, 32'h10, 32'h0);
    chk("unmapped", 32'h0, rdv);
    bus(1'b1, 32'h0, 32'h915);
    bus(1'b1, 32'h0, 32'h115);
    bus(1'b0, 32'h4, 32'h0);
    chk("hunt", 32'h1, {30'h0, rdv[1:0]});
    bus(1'b1, 32'h0, 32'h515);
    bus(1'b0, 32'h4, 32'h0);
    chk("held", 32'h1, {30'h0, rdv[1:0]});
    rx(10'h27B, 10'h000, ST_DATA);
    bus(1'b0, 32'h4, 32'h0);
    chk("run", 32'h2, {30'h0, rdv[1:0]});
    rx(10'h27B, 10'h000, ST_BUILT_IN_SELFTEST_ERR);
    repeat (15) rx(10'h27B, 10'h000, ST_BUILT_IN_SELFTEST_ERR);
    bus(1'b0, 32'h4, 32'h0);
    chk("abort", 32'h1, {30'h0, rdv[1:0]});
    @(posedge hclk);
    device_reset_low <= 1'b0;
    repeat (2) @(posedge hclk);
    device_reset_low <= 1'b1;
    bus(1'b0, 32'h4, 32'h0);
    chk("off", 32'h0, {30'h0, rdv[1:0]});
    bus(1'b1, 32'h0, 32'hD25);
    rx(10'h0FA, 10'h0BC, ST_FRAME_B);
    // buffered: written on the strobe edge, popped one tick later
    bus(1'b1, 32'h0, 32'hD19);
    @(posedge hclk);
    snd  <= 1'b1;
    cval <= 10'h1DB;
    @(posedge hclk);
    snd  <= 1'b0;
    @(posedge hclk);
    atk  <= 1'b1;
    @(posedge hclk);
    atk  <= 1'b0;
    #1;
    chk("eb_valid", 32'h1, {31'h0, rx_valid});
    chk("eb_data", 32'h1, {22'h0, rx_data});
    chk("eb_status", {29'h0, ST_DATA}, {29'h0, rx_st});
    chk("eb_parity", 32'h0, {31'h0, rx_parity});
    chk("shared_clk_eb", 32'h1, {31'h0, sh_clk});
    chk("rec_clk_eb", 32'h0, {31'h0, rec_clk});
    @(posedge hclk);
    atk  <= 1'b1;
    @(posedge hclk);
    atk  <= 1'b0;
    bus(1'b0, 32'h4, 32'h0);
    chk("eb_flags", 32'h2, {26'h0, rdv[7:2]});
    bus(1'b1, 32'h4, 32'h8);
    bus(1'b0, 32'h4, 32'h0);
    chk("unf_clear", 32'h0, {31'h0, rdv[3]});
    test_done();
  end
endmodule : tb_top
`default_nettype wire
